// *** design/lcg_pkg.sv ***
// Package with register map, field positions and reset values for the gate 1 data select block
package lcg_pkg;
	localparam logic [11:0] LCG_ADDR_SEL = 12'h000;
	localparam logic [11:0] LCG_ADDR_GATE = 12'h004;
	localparam int LCG_SEL_WIDTH = 8;
	localparam logic [7:0] LCG_SEL_RESET = 8'h00;
	localparam int LCG_BIT_IN1_INV = 0;
	localparam int LCG_BIT_IN1_TRUE = 1;
	localparam int LCG_BIT_IN2_INV = 2;
	localparam int LCG_BIT_IN2_TRUE = 3;
	localparam int LCG_BIT_IN3_INV = 4;
	localparam int LCG_BIT_IN3_TRUE = 5;
	localparam int LCG_BIT_IN4_INV = 6;
	localparam int LCG_BIT_IN4_TRUE = 7;
endpackage

// *** design/lcg_or_gate.sv ***
// Gated OR of selected data terms
`timescale 1ns/1ps
module lcg_or_gate (
	input wire logic [7:0] sel,
	input wire logic [7:0] terms,
	output logic gate
);
	// Unselected terms are forced low so an empty selection gives a low gate
	always_comb begin
		gate = |(sel & terms);
	end
endmodule

// *** design/lcg_gate1_select.sv ***
// Gate 1 data select of a configurable logic cell with APB register access
//
// Overview of operation
// - Selector bit 6 set routes the inverted data input 4 into gate 1, clear excludes it.
// - Selector bit 5 set routes the true data input 3 into gate 1, clear excludes it.
// - Selector bit 4 set routes the inverted data input 3 into gate 1, clear excludes it.
// - Selector bit 3 set routes the true data input 2 into gate 1, clear excludes it.
// - Selector bit 2 set routes the inverted data input 2 into gate 1, clear excludes it.
// - Selector bit 1 set routes the true data input 1 into gate 1, clear excludes it.
// - Selector bit 0 set routes the inverted data input 1 into gate 1, clear excludes it.
// - Selector bit 7 set routes the true data input 4 into gate 1, clear excludes it.
`timescale 1ns/1ps
module lcg_gate1_select (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic data_in1_true,
	input wire logic data_in1_inverted,
	input wire logic data_in2_true,
	input wire logic data_in2_inverted,
	input wire logic data_in3_true,
	input wire logic data_in3_inverted,
	input wire logic data_in4_true,
	input wire logic data_in4_inverted,
	output logic cell_gate_one
);
	logic [7:0] gate1_input_select_q;
	logic [7:0] gate1_input_select_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;
	logic pready_q;
	logic pready_d;
	logic gate_q;
	logic gate_d;
	logic [7:0] terms;
	logic gate_comb;
	logic setup;
	logic access;
	logic hit_sel;
	logic hit_gate;
	logic hit_none;
	logic wr_sel;
	logic [31:0] rd_word;

	// Bit order of the term vector matches the selector field layout
	always_comb begin
		terms = '0;
		terms[lcg_pkg::LCG_BIT_IN1_INV] = data_in1_inverted;
		terms[lcg_pkg::LCG_BIT_IN1_TRUE] = data_in1_true;
		terms[lcg_pkg::LCG_BIT_IN2_INV] = data_in2_inverted;
		terms[lcg_pkg::LCG_BIT_IN2_TRUE] = data_in2_true;
		terms[lcg_pkg::LCG_BIT_IN3_INV] = data_in3_inverted;
		terms[lcg_pkg::LCG_BIT_IN3_TRUE] = data_in3_true;
		terms[lcg_pkg::LCG_BIT_IN4_INV] = data_in4_inverted;
		terms[lcg_pkg::LCG_BIT_IN4_TRUE] = data_in4_true;
	end

	lcg_or_gate u_or (
		.sel(gate1_input_select_q),
		.terms(terms),
		.gate(gate_comb)
	);

	// Bus phase and address decode
	always_comb begin
		setup = psel && !penable;
		access = psel && penable;
		hit_sel = (paddr == lcg_pkg::LCG_ADDR_SEL);
		hit_gate = (paddr == lcg_pkg::LCG_ADDR_GATE);
		hit_none = !hit_sel && !hit_gate;
		wr_sel = access && pwrite && hit_sel;
	end

	// Read word of the addressed register; unused upper bits read as zero
	always_comb begin
		rd_word = '0;
		if (hit_sel) begin
			rd_word[lcg_pkg::LCG_BIT_IN1_INV] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN1_INV];
			rd_word[lcg_pkg::LCG_BIT_IN1_TRUE] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN1_TRUE];
			rd_word[lcg_pkg::LCG_BIT_IN2_INV] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN2_INV];
			rd_word[lcg_pkg::LCG_BIT_IN2_TRUE] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN2_TRUE];
			rd_word[lcg_pkg::LCG_BIT_IN3_INV] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN3_INV];
			rd_word[lcg_pkg::LCG_BIT_IN3_TRUE] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN3_TRUE];
			rd_word[lcg_pkg::LCG_BIT_IN4_INV] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN4_INV];
			rd_word[lcg_pkg::LCG_BIT_IN4_TRUE] = gate1_input_select_q[lcg_pkg::LCG_BIT_IN4_TRUE];
		end else if (hit_gate) begin
			rd_word[0] = gate_q;
		end
	end

	// Selector group: only a completed write to the selector offset changes it; the status word is read only
	always_comb begin
		gate1_input_select_d = gate1_input_select_q;
		if (wr_sel) begin
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN1_INV] = pwdata[lcg_pkg::LCG_BIT_IN1_INV];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN1_TRUE] = pwdata[lcg_pkg::LCG_BIT_IN1_TRUE];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN2_INV] = pwdata[lcg_pkg::LCG_BIT_IN2_INV];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN2_TRUE] = pwdata[lcg_pkg::LCG_BIT_IN2_TRUE];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN3_INV] = pwdata[lcg_pkg::LCG_BIT_IN3_INV];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN3_TRUE] = pwdata[lcg_pkg::LCG_BIT_IN3_TRUE];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN4_INV] = pwdata[lcg_pkg::LCG_BIT_IN4_INV];
			gate1_input_select_d[lcg_pkg::LCG_BIT_IN4_TRUE] = pwdata[lcg_pkg::LCG_BIT_IN4_TRUE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate1_input_select_q <= lcg_pkg::LCG_SEL_RESET;
		end else begin
			gate1_input_select_q <= gate1_input_select_d;
		end
	end

	// Read data group: captured at the setup edge, so it already stands for the whole access phase
	always_comb begin
		prdata_d = prdata_q;
		if (setup) begin
			prdata_d = rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	// Error group: set by a setup cycle to an unmapped offset and cleared at the access edge
	always_comb begin
		pslverr_d = 1'b0;
		if (setup && hit_none) begin
			pslverr_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= pslverr_d;
		end
	end

	// Ready group: no wait states, the answer is prepared in the setup cycle
	always_comb begin
		pready_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b1;
		end else begin
			pready_q <= pready_d;
		end
	end

	// Gate group: registered so the pin is glitch free, at the cost of one cycle of latency
	always_comb begin
		gate_d = gate_comb;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= 1'b0;
		end else begin
			gate_q <= gate_d;
		end
	end

	// Gate output is registered, so it trails its inputs by one cycle
	always_comb begin
		prdata = prdata_q;
		pslverr = pslverr_q;
		pready = pready_q;
		cell_gate_one = gate_q;
	end
endmodule

// *** dv/lcg_assertions.sv ***
// Assertions on the gate 1 data select output cell_gate_one
`timescale 1ns/1ps
module lcg_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic cell_gate_one,
	input wire logic data_in1_inverted,
	input wire logic data_in1_true,
	input wire logic data_in2_inverted,
	input wire logic data_in2_true,
	input wire logic data_in3_inverted,
	input wire logic data_in3_true,
	input wire logic data_in4_inverted,
	input wire logic data_in4_true
);
	wire [7:0] t = {data_in4_true, data_in4_inverted, data_in3_true, data_in3_inverted, data_in2_true,
		data_in2_inverted, data_in1_true, data_in1_inverted};
	wire g = cell_gate_one;
	logic [7:0] s_q, s_d;
	// Selector has no port, so it is mirrored from completed writes
	always_comb s_d = psel && penable && pwrite && paddr == lcg_pkg::LCG_ADDR_SEL ? pwdata[7:0] : s_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) s_q <= lcg_pkg::LCG_SEL_RESET;
		else s_q <= s_d;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_b0; s_q[0] && t[0] |=> g; endproperty
	a_b0: assert property (p_b0) else $error("b0");
	property p_b1; s_q[1] && t[1] |=> g; endproperty
	a_b1: assert property (p_b1) else $error("b1");
	property p_b2; s_q[2] && t[2] |=> g; endproperty
	a_b2: assert property (p_b2) else $error("b2");
	property p_b3; s_q[3] && t[3] |=> g; endproperty
	a_b3: assert property (p_b3) else $error("b3");
	property p_b4; s_q[4] && t[4] |=> g; endproperty
	a_b4: assert property (p_b4) else $error("b4");
	property p_b5; s_q[5] && t[5] |=> g; endproperty
	a_b5: assert property (p_b5) else $error("b5");
	property p_b6; s_q[6] && t[6] |=> g; endproperty
	a_b6: assert property (p_b6) else $error("b6");
	property p_b7; s_q[7] && t[7] |=> g; endproperty
	a_b7: assert property (p_b7) else $error("b7");
	property p_none; !(|(s_q & t)) |=> !g; endproperty
	a_none: assert property (p_none) else $error("none");
	c_w: cover property (s_d != s_q);
	c_hi: cover property (s_q[7] && g);
	c_lo: cover property (s_q != 8'h00 && !g);
endmodule

// *** dv/tb.sv ***
// Bench for the gate 1 data select block
`timescale 1ns/1ps
bind lcg_gate1_select lcg_chk lcg_chk_inst (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.cell_gate_one(cell_gate_one),
	.data_in1_inverted(data_in1_inverted),
	.data_in1_true(data_in1_true),
	.data_in2_inverted(data_in2_inverted),
	.data_in2_true(data_in2_true),
	.data_in3_inverted(data_in3_inverted),
	.data_in3_true(data_in3_true),
	.data_in4_inverted(data_in4_inverted),
	.data_in4_true(data_in4_true)
);
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, cell_gate_one, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] t = 0;
	logic [16:0] rows [3] = '{{8'h00, 8'hff, 1'b0}, {8'h0a, 8'h08, 1'b1}, {8'hff, 8'h00, 1'b0}};
	int err_count = 0, n_tests = 0, i, k;
	lcg_gate1_select lcg_gate1_select_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cell_gate_one(cell_gate_one), .data_in1_inverted(t[0]), .data_in1_true(t[1]),
		.data_in2_inverted(t[2]), .data_in2_true(t[3]), .data_in3_inverted(t[4]), .data_in3_true(t[5]),
		.data_in4_inverted(t[6]), .data_in4_true(t[7]));
	initial begin
		forever #5 pclk = ~pclk;
	end
	task end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task ck(input string n, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		// Idle edge first, so back-to-back calls never drive psel twice in one time step
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1;
		k = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 9);
		rd = prdata; er = pslverr;
		psel <= 0; penable <= 0;
		if (k == 9) begin
			err_count++;
			end_sim();
		end
	endtask
	task gt(input logic [7:0] s, v, input logic e);
		ap(1, 12'h000, {24'hffffff, s});
		t <= v;
		repeat (2) @(posedge pclk);
		#1 ck("gate", {31'h0, e}, {31'h0, cell_gate_one});
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		ap(0, 12'h000, 0); ck("sel reset", 0, rd);
		foreach (rows[j]) gt(rows[j][16:9], rows[j][8:1], rows[j][0]);
		$display("table done");
		// Odd passes select the term, even passes feed every other term to prove exclusion
		for (i = 0; i < 16; i++) gt(8'h01 << i/2, i[0] ? 8'h01 << i/2 : ~(8'h01 << i/2), i[0]);
		ap(0, 12'h000, 0); ck("sel read", 32'h80, rd);
		ck("sel err", 0, {31'h0, er});
		ap(0, 12'h004, 0); ck("gate status", 1, rd);
		ap(1, 12'h004, 0); ck("status write err", 0, {31'h0, er});
		ap(1, 12'h008, 0); ck("unmapped write err", 1, {31'h0, er});
		ap(0, 12'h000, 0); ck("sel kept", 32'h80, rd);
		ap(0, 12'h008, 0); ck("unmapped", 32'h1, {31'h0, er});
		ck("unmapped data", 0, rd);
		$display("bits done");
		@(posedge pclk) presetn <= 0;
		repeat (3) @(posedge pclk);
		ck("gate in reset", 0, {31'h0, cell_gate_one});
		ck("ready in reset", 1, {31'h0, pready});
		presetn <= 1;
		ap(0, 12'h000, 0); ck("sel after reset", 0, rd);
		$display("reset done");
		end_sim();
	end
endmodule
